// [pps_defines.vh]
`ifndef PPS_DEFINES_VH
`define PPS_DEFINES_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define PPS_REG_CTRL       12'h000
`define PPS_REG_STATUS     12'h004
`define PPS_REG_OLP_LVL    12'h008
`define PPS_REG_OVP_LVL    12'h00C
`define PPS_REG_REF_LVL    12'h010
`define PPS_REG_UVP_LVL    12'h014
`define PPS_REG_BI_LVL     12'h018
`define PPS_REG_BO_LVL     12'h01C
`define PPS_REG_UVP_BLK    12'h020
`define PPS_REG_BO_BLK     12'h024
`define PPS_REG_OV2_FLT    12'h028
`define PPS_REG_CCM_LIM    12'h02C
`define PPS_REG_AR_BRK     12'h030
`define PPS_REG_MAXPER     12'h034
`define PPS_REG_TONMIN     12'h038
`define PPS_REG_BUS_AVG    12'h03C
`define PPS_REG_AC_RMS     12'h040
`define PPS_REG_CCM_CNT    12'h044

// ----------------------------------------------------------------
// field layout and widths
// ----------------------------------------------------------------
`define PPS_W_LVL          12
`define PPS_W_CNT          16
`define PPS_CTRL_EN        0
`define PPS_CTRL_BUS_LD    1
`define PPS_CTRL_AC_LD     2
`define PPS_ZERO32         32'h0000_0000

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPS_RST_LVL        12'h000
`define PPS_RST_CNT        16'h0000
`define PPS_RST_BRK        16'h1000
`define PPS_RST_MAXPER     16'h0320
`define PPS_RST_TONMIN     16'h0020

// ----------------------------------------------------------------
// timing: ccm margin 200 ns at 125 MHz
// ----------------------------------------------------------------
`define PPS_CCM_MARGIN_NS  200
`define PPS_CLK_MHZ        125
`define PPS_CCM_MARGIN_CYC 16'h0019

`endif

// [pps_sync.v]
`include "pps_defines.vh"

module pps_sync (
  input  wire       i_core_clk,
  input  wire       i_rst_b,
  input  wire [3:0] i_async,
  output wire [3:0] o_sync
);
  reg [3:0] meta;
  reg [3:0] sync;

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= 4'h0;
      sync <= 4'h0;
    end else begin
      meta <= i_async;
      sync <= meta;
    end
  end

  assign o_sync = sync;
endmodule

// [pps_gate.v]
`include "pps_defines.vh"

module pps_gate (
  input  wire                 i_core_clk,
  input  wire                 i_rst_b,
  input  wire                 i_run,
  input  wire                 i_ocp,
  input  wire                 i_zcd,
  input  wire [`PPS_W_CNT-1:0] i_ton,
  input  wire [`PPS_W_CNT-1:0] i_max_per,
  output reg                  o_gate,
  output reg                  o_cyc_end,
  output reg                  o_timeout,
  output reg  [`PPS_W_CNT-1:0] o_ton_used
);
  reg [`PPS_W_CNT-1:0] t;
  reg                  on;
  reg                  zcd_d;
  wire                 zcd_rise = i_zcd & ~zcd_d;
  wire                 expire = (t >= i_max_per);

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t          <= `PPS_RST_CNT;
      on         <= 1'b0;
      o_gate     <= 1'b0;
      zcd_d      <= 1'b0;
      o_cyc_end  <= 1'b0;
      o_timeout  <= 1'b0;
      o_ton_used <= `PPS_RST_CNT;
    end else begin
      zcd_d     <= i_zcd;
      o_cyc_end <= 1'b0;
      o_timeout <= 1'b0;
      if (!i_run) begin
        t      <= `PPS_RST_CNT;
        on     <= 1'b0;
        o_gate <= 1'b0;
      end else if (on) begin
        t <= t + 16'h0001;
        // cut on overcurrent for rest of cycle
        if (i_ocp || t >= i_ton) begin
          on     <= 1'b0;
          o_gate <= 1'b0;
          o_ton_used <= t;
        end
      end else if (zcd_rise || expire) begin
        // restart only on zcd or max period, each cycle
        // on-time compared live against the shaping input, not latched per cycle
        o_cyc_end <= 1'b1;
        o_timeout <= expire & ~zcd_rise;
        t         <= `PPS_RST_CNT;
        on        <= 1'b1;
        o_gate    <= ~i_ocp;
      end else begin
        t <= t + 16'h0001;
      end
    end
  end
endmodule

// [pps_supervisor.v]
`include "pps_defines.vh"

module pps_supervisor (
  input  wire        i_core_clk,
  input  wire        i_rst_b,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_uvlo_ok,
  input  wire        i_ocp_cmp,
  input  wire        i_comparator_overvoltage_stage_cmp,
  input  wire        i_zero_crossing_detect,
  input  wire [15:0] i_on_time,
  output reg         o_boost_gate,
  output reg         o_boost_enable,
  output reg         o_bridge_enable
);

  // ----------------------------------------------------------------
  // supervisor states
  // ----------------------------------------------------------------
  localparam [2:0] ST_WAIT_BI = 3'b000;
  localparam [2:0] ST_START   = 3'b001;
  localparam [2:0] ST_RUN     = 3'b010;
  localparam [2:0] ST_RESTART = 3'b011;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [3:0] syn;
  wire       ocp_s  = syn[0];
  wire       comparator_overvoltage_stage_s = syn[1];
  wire       zcd_s  = syn[2];
  wire       uvlo_s = syn[3];

  pps_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({i_uvlo_ok, i_zero_crossing_detect, i_comparator_overvoltage_stage_cmp, i_ocp_cmp}),
    .o_sync     (syn)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg                  enable;
  reg [`PPS_W_LVL-1:0] olp_lvl;
  reg [`PPS_W_LVL-1:0] ovp_lvl;
  reg [`PPS_W_LVL-1:0] ref_lvl;
  reg [`PPS_W_LVL-1:0] uvp_lvl;
  reg [`PPS_W_LVL-1:0] bi_lvl;
  reg [`PPS_W_LVL-1:0] bo_lvl;
  reg [`PPS_W_CNT-1:0] uvp_blk;
  reg [`PPS_W_CNT-1:0] bo_blk;
  reg [`PPS_W_CNT-1:0] ov2_flt;
  reg [`PPS_W_CNT-1:0] ccm_lim;
  reg [`PPS_W_CNT-1:0] ar_brk;
  reg [`PPS_W_CNT-1:0] max_per;
  reg [`PPS_W_CNT-1:0] ton_min;
  reg [`PPS_W_LVL-1:0] bus_avg;
  reg [`PPS_W_LVL-1:0] ac_rms;
  reg                  bus_new;
  reg                  ac_new;

  // status flags and state
  reg [2:0]            state;
  reg                  averaged_overvoltage_stage;
  reg                  comparator_overvoltage_stage;
  reg                  uvp;
  reg                  bo;
  reg                  ran;
  reg [`PPS_W_CNT-1:0] ccm_cnt;
  reg [`PPS_W_CNT-1:0] uvp_t;
  reg [`PPS_W_CNT-1:0] bo_t;
  reg [`PPS_W_CNT-1:0] ov2_t;
  reg [`PPS_W_CNT-1:0] brk_t;

  function [31:0] pps_rd;
    input [11:0] a;
    begin
      case (a)
        `PPS_REG_CTRL:    pps_rd = {31'h0, enable};
        `PPS_REG_STATUS:  pps_rd = {23'h0, ran, bo, uvp, comparator_overvoltage_stage, averaged_overvoltage_stage, state, 1'b0};
        `PPS_REG_OLP_LVL: pps_rd = {20'h0, olp_lvl};
        `PPS_REG_OVP_LVL: pps_rd = {20'h0, ovp_lvl};
        `PPS_REG_REF_LVL: pps_rd = {20'h0, ref_lvl};
        `PPS_REG_UVP_LVL: pps_rd = {20'h0, uvp_lvl};
        `PPS_REG_BI_LVL:  pps_rd = {20'h0, bi_lvl};
        `PPS_REG_BO_LVL:  pps_rd = {20'h0, bo_lvl};
        `PPS_REG_UVP_BLK: pps_rd = {16'h0, uvp_blk};
        `PPS_REG_BO_BLK:  pps_rd = {16'h0, bo_blk};
        `PPS_REG_OV2_FLT: pps_rd = {16'h0, ov2_flt};
        `PPS_REG_CCM_LIM: pps_rd = {16'h0, ccm_lim};
        `PPS_REG_AR_BRK:  pps_rd = {16'h0, ar_brk};
        `PPS_REG_MAXPER:  pps_rd = {16'h0, max_per};
        `PPS_REG_TONMIN:  pps_rd = {16'h0, ton_min};
        `PPS_REG_BUS_AVG: pps_rd = {20'h0, bus_avg};
        `PPS_REG_AC_RMS:  pps_rd = {20'h0, ac_rms};
        `PPS_REG_CCM_CNT: pps_rd = {16'h0, ccm_cnt};
        default:          pps_rd = `PPS_ZERO32;
      endcase
    end
  endfunction

  function pps_hit;
    input [11:0] a;
    begin
      pps_hit = (a <= `PPS_REG_CCM_CNT) && (a[1:0] == 2'h0);
    end
  endfunction

  // ----------------------------------------------------------------
  // apb slave: one wait state, ready registered one cycle after access
  // ----------------------------------------------------------------
  wire acc = i_psel & i_penable & ~o_pready;
  wire wr  = acc & i_pwrite & pps_hit(i_paddr);

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= `PPS_ZERO32;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc & ~pps_hit(i_paddr);
      o_prdata  <= (acc & ~i_pwrite) ? pps_rd(i_paddr) : `PPS_ZERO32;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable  <= 1'b0;
      olp_lvl <= `PPS_RST_LVL;
      ovp_lvl <= `PPS_RST_LVL;
      ref_lvl <= `PPS_RST_LVL;
      uvp_lvl <= `PPS_RST_LVL;
      bi_lvl  <= `PPS_RST_LVL;
      bo_lvl  <= `PPS_RST_LVL;
      uvp_blk <= `PPS_RST_BRK;
      bo_blk  <= `PPS_RST_BRK;
      ov2_flt <= `PPS_RST_BRK;
      ccm_lim <= `PPS_RST_BRK;
      ar_brk  <= `PPS_RST_BRK;
      max_per <= `PPS_RST_MAXPER;
      ton_min <= `PPS_RST_TONMIN;
      bus_avg <= `PPS_RST_LVL;
      ac_rms  <= `PPS_RST_LVL;
      bus_new <= 1'b0;
      ac_new  <= 1'b0;
    end else begin
      bus_new <= 1'b0;
      ac_new  <= 1'b0;
      if (wr) begin
        case (i_paddr)
          `PPS_REG_CTRL:    enable  <= i_pwdata[`PPS_CTRL_EN];
          `PPS_REG_OLP_LVL: olp_lvl <= i_pwdata[`PPS_W_LVL-1:0];
          `PPS_REG_OVP_LVL: ovp_lvl <= i_pwdata[`PPS_W_LVL-1:0];
          `PPS_REG_REF_LVL: ref_lvl <= i_pwdata[`PPS_W_LVL-1:0];
          `PPS_REG_UVP_LVL: uvp_lvl <= i_pwdata[`PPS_W_LVL-1:0];
          `PPS_REG_BI_LVL:  bi_lvl  <= i_pwdata[`PPS_W_LVL-1:0];
          `PPS_REG_BO_LVL:  bo_lvl  <= i_pwdata[`PPS_W_LVL-1:0];
          `PPS_REG_UVP_BLK: uvp_blk <= i_pwdata[`PPS_W_CNT-1:0];
          `PPS_REG_BO_BLK:  bo_blk  <= i_pwdata[`PPS_W_CNT-1:0];
          `PPS_REG_OV2_FLT: ov2_flt <= i_pwdata[`PPS_W_CNT-1:0];
          `PPS_REG_CCM_LIM: ccm_lim <= i_pwdata[`PPS_W_CNT-1:0];
          `PPS_REG_AR_BRK:  ar_brk  <= i_pwdata[`PPS_W_CNT-1:0];
          `PPS_REG_MAXPER:  max_per <= i_pwdata[`PPS_W_CNT-1:0];
          `PPS_REG_TONMIN:  ton_min <= i_pwdata[`PPS_W_CNT-1:0];
          `PPS_REG_BUS_AVG: begin
            bus_avg <= i_pwdata[`PPS_W_LVL-1:0];
            bus_new <= 1'b1;
          end
          `PPS_REG_AC_RMS: begin
            ac_rms <= i_pwdata[`PPS_W_LVL-1:0];
            ac_new <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // switching cell
  // ----------------------------------------------------------------
  wire                  gate;
  wire                  cyc_end;
  wire                  timeout;
  wire [`PPS_W_CNT-1:0] ton_used;
  wire                  boost_run = (state == ST_RUN) & ~(averaged_overvoltage_stage | comparator_overvoltage_stage | uvp | bo);

  pps_gate u_gate (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_run      (boost_run),
    .i_ocp      (ocp_s),
    .i_zcd      (zcd_s),
    .i_ton      (i_on_time),
    .i_max_per  (max_per),
    .o_gate     (gate),
    .o_cyc_end  (cyc_end),
    .o_timeout  (timeout),
    .o_ton_used (ton_used)
  );

  // ----------------------------------------------------------------
  // supervisor
  // ----------------------------------------------------------------
  // levels are firmware averaged samples, so compares are cheap here
  wire olp_low = bus_avg < olp_lvl;
  wire ccm_ok  = ton_used > (ton_min + `PPS_CCM_MARGIN_CYC);
  wire restart_req;
  assign restart_req = (olp_low & ran) | (ccm_cnt > ccm_lim);

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state   <= ST_WAIT_BI;
      averaged_overvoltage_stage    <= 1'b0;
      comparator_overvoltage_stage    <= 1'b0;
      uvp     <= 1'b0;
      bo      <= 1'b0;
      ran     <= 1'b0;
      ccm_cnt <= `PPS_RST_CNT;
      uvp_t   <= `PPS_RST_CNT;
      bo_t    <= `PPS_RST_CNT;
      ov2_t   <= `PPS_RST_CNT;
      brk_t   <= `PPS_RST_CNT;
    end else if (!uvlo_s || !enable) begin
      state   <= ST_WAIT_BI;
      ran     <= 1'b0;
      averaged_overvoltage_stage    <= 1'b0;
      comparator_overvoltage_stage    <= 1'b0;
      uvp     <= 1'b0;
      bo      <= 1'b0;
      ccm_cnt <= `PPS_RST_CNT;
    end else begin
      case (state)
        ST_WAIT_BI: begin
          if (ac_new && ac_rms > bi_lvl)
            state <= ST_START;
        end
        ST_START: begin
          ccm_cnt <= `PPS_RST_CNT;
          uvp_t   <= `PPS_RST_CNT;
          bo_t    <= `PPS_RST_CNT;
          ov2_t   <= `PPS_RST_CNT;
          averaged_overvoltage_stage    <= 1'b0;
          comparator_overvoltage_stage    <= 1'b0;
          uvp     <= 1'b0;
          bo      <= 1'b0;
          if (!olp_low)
            state <= ST_RUN;
        end
        ST_RUN: begin
          ran <= 1'b1;
          if (restart_req) begin
            state <= ST_RESTART;
            brk_t <= `PPS_RST_CNT;
          end
          // averaged overvoltage; recovery at reference
          if (bus_new && bus_avg > ovp_lvl)
            averaged_overvoltage_stage <= 1'b1;
          else if (bus_new && bus_avg <= ref_lvl)
            averaged_overvoltage_stage <= 1'b0;
          // comparator must hold for the filter delay
          ov2_t <= comparator_overvoltage_stage_s ? ov2_t + 16'h0001 : `PPS_RST_CNT;
          if (comparator_overvoltage_stage_s && ov2_t >= ov2_flt)
            comparator_overvoltage_stage <= 1'b1;
          else if (bus_new && bus_avg <= ref_lvl)
            comparator_overvoltage_stage <= 1'b0;
          // undervoltage blanking
          if (bus_avg < uvp_lvl) begin
            if (uvp_t >= uvp_blk)
              uvp <= 1'b1;
            else
              uvp_t <= uvp_t + 16'h0001;
          end else
            uvp_t <= `PPS_RST_CNT;
          // brownout blanking
          if (ac_rms < bo_lvl) begin
            if (bo_t >= bo_blk)
              bo <= 1'b1;
            else
              bo_t <= bo_t + 16'h0001;
          end else
            bo_t <= `PPS_RST_CNT;
          // ccm counting, gated by on-time margin
          if (cyc_end && ccm_ok) begin
            if (timeout)
              ccm_cnt <= ccm_cnt + 16'h0001;
            else if (ccm_cnt != `PPS_RST_CNT)
              ccm_cnt <= ccm_cnt - 16'h0001;
          end
        end
        ST_RESTART: begin
          // both stages off through the break
          brk_t <= brk_t + 16'h0001;
          if (brk_t >= ar_brk)
            state <= ST_START;
        end
        default: state <= ST_WAIT_BI;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_boost_gate    <= 1'b0;
      o_boost_enable  <= 1'b0;
      o_bridge_enable <= 1'b0;
    end else begin
      o_boost_gate    <= gate & boost_run & ~ocp_s;
      o_boost_enable  <= boost_run;
      o_bridge_enable <= (state == ST_RUN);
    end
  end

endmodule

// [pps_props.sv]
`include "pps_defines.vh"

module pps_props (
  input wire        i_core_clk,
  input wire        i_rst_b,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        i_uvlo_ok,
  input wire        i_ocp_cmp,
  input wire        i_comparator_overvoltage_stage_cmp,
  input wire        o_boost_gate,
  input wire        o_boost_enable,
  input wire        o_bridge_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------------------------------
  // shadow of the filter delay, snooped from completed writes
  // ----------------------------------------------------------------
  reg [15:0] flt;
  reg [15:0] ov_cnt;
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flt    <= 16'h1000;
      ov_cnt <= 16'h0000;
    end else begin
      if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == `PPS_REG_OV2_FLT)
        flt <= i_pwdata[15:0];
      ov_cnt <= !i_comparator_overvoltage_stage_cmp ? 16'h0000 : (&ov_cnt ? ov_cnt : ov_cnt + 16'h0001);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // margin of 8 covers the sync stages and the output flop
  a_comparator_overvoltage_stage_filter_stop: assert property (ov_cnt == flt + 16'h0008 |-> !o_boost_enable)
    else $error("boost still enabled after filtered overvoltage");
  a_ocp_gate_cut: assert property ($rose(i_ocp_cmp) ##0 i_ocp_cmp [*5] |-> !o_boost_gate)
    else $error("gate still high after overcurrent");
  a_gate_needs_boost: assert property (!o_boost_enable [*3] |-> !o_boost_gate)
    else $error("gate switching while boost stopped");
  a_bridge_off_idle: assert property (!o_bridge_enable [*3] |-> !o_boost_gate)
    else $error("gate switching while bridge halted");
  a_uvlo_all_off: assert property (!i_uvlo_ok [*6] |-> !o_bridge_enable && !o_boost_enable)
    else $error("stage enabled under supply lockout");
  a_apb_one_wait: assert property (i_psel && i_penable && !$past(i_penable)
    |-> !o_pready ##1 o_pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_unmapped_err: assert property (o_pready && (i_paddr > 12'h044 || i_paddr[1:0] != 2'h0)
    |-> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_idle_bus_quiet: assert property (!o_pready |-> o_prdata == 32'h0000_0000 && !o_pslverr)
    else $error("read data or error outside ready");

  c_ocp: cover property ($rose(i_ocp_cmp) ##4 !o_boost_gate);
  c_comparator_overvoltage_stage: cover property (ov_cnt == flt + 16'h0008);
  c_slverr: cover property (o_pready && o_pslverr);
endmodule

bind pps_supervisor pps_props i_pps_props (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_uvlo_ok(i_uvlo_ok), .i_ocp_cmp(i_ocp_cmp), .i_comparator_overvoltage_stage_cmp(i_comparator_overvoltage_stage_cmp),
  .o_boost_gate(o_boost_gate), .o_boost_enable(o_boost_enable),
  .o_bridge_enable(o_bridge_enable));

// [pps_stage.sv]
module pps_stage (
  input  wire       i_core_clk,
  input  wire       i_gate,
  input  wire       i_ccm,
  input  wire [7:0] i_ocp_after,
  output logic      o_zcd,
  output logic      o_ocp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] on_cnt = 8'h00;
  logic [7:0] off_cnt = 8'hFF;
  initial o_zcd = 1'b0;
  initial o_ocp = 1'b0;

  // ----------------------------------------------------------------
  // choke current and shunt comparator
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    on_cnt  <= i_gate ? on_cnt + 8'h01 : 8'h00;
    off_cnt <= i_gate ? 8'h00 : (&off_cnt ? off_cnt : off_cnt + 8'h01);
    // trip level reached after i_ocp_after cycles of gate on; 0 means never
    if (i_ocp_after != 8'h00 && on_cnt == i_ocp_after)
      o_ocp <= 1'b1;
    else if (!i_gate && off_cnt > 8'h06)
      o_ocp <= 1'b0;
    // ringing only after demagnetisation; none in continuous conduction
    o_zcd <= !i_ccm && off_cnt[7:2] == 6'h03;
  end
endmodule

// [tb_pps_supervisor.sv]
`include "pps_defines.vh"

module tb_pps_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        uvlo_ok = 1'b0;
  logic        comparator_overvoltage_stage = 1'b0;
  logic        ccm = 1'b0;
  logic [15:0] on_time = 16'h0028;
  logic [7:0]  ocp_after = 8'h00;
  logic [31:0] prdata;
  logic        pready, pslverr, zero_crossing_detect, ocp, gate, boost_en, bridge_en;
  logic [31:0] q;
  logic        qe;
  int          n_fail = 0;
  int          num_checks = 0;

  always #4 clk = ~clk;

  pps_supervisor i_pps_supervisor (.i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_uvlo_ok(uvlo_ok),
    .i_ocp_cmp(ocp), .i_comparator_overvoltage_stage_cmp(comparator_overvoltage_stage), .i_zero_crossing_detect(zero_crossing_detect), .i_on_time(on_time),
    .o_boost_gate(gate), .o_boost_enable(boost_en), .o_bridge_enable(bridge_en));
  pps_stage i_pps_stage (.i_core_clk(clk), .i_gate(gate), .i_ccm(ccm),
    .i_ocp_after(ocp_after), .o_zcd(zero_crossing_detect), .o_ocp(ocp));

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait limit here: a silent slave is left to the watchdog
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x, m);
  endtask
  // polls on the settled half of the cycle, bounded
  task wait_out(input int s, input logic v);
    int n;
    n = 0;
    while ((s == 0 ? boost_en : s == 1 ? bridge_en : gate) !== v && n < 4000) begin
      n++;
      @(negedge clk);
    end
    if (n >= 4000) begin
      n_fail++;
      $display("wrong value at %0t: output wait timed out", $time);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(`PPS_REG_CTRL, 32'h0000_0000, "ctrl reset");
    rd(`PPS_REG_AR_BRK, 32'h0000_1000, "break reset");
    rd(`PPS_REG_MAXPER, 32'h0000_0320, "period reset");
    rd(`PPS_REG_TONMIN, 32'h0000_0020, "on-time reset");
    wr(12'h048, 32'h0000_00FF);
    rd(12'h048, 32'h0000_0000, "unmapped");
    chk(qe, 1'b1, "unmapped refused");
    @(negedge clk);
    chk(pslverr, 1'b0, "error dropped");
    wr(`PPS_REG_CCM_CNT, 32'h0000_00FF);
    rd(`PPS_REG_CCM_CNT, 32'h0000_0000, "counter read-only");
    wr(`PPS_REG_OLP_LVL, 32'h0000_0100);
    wr(`PPS_REG_OVP_LVL, 32'h0000_0800);
    wr(`PPS_REG_REF_LVL, 32'h0000_0600);
    wr(`PPS_REG_UVP_LVL, 32'h0000_0000);
    wr(`PPS_REG_BI_LVL, 32'h0000_0400);
    wr(`PPS_REG_BO_LVL, 32'h0000_0200);
    wr(`PPS_REG_BO_BLK, 32'h0000_000A);
    wr(`PPS_REG_OV2_FLT, 32'h0000_000A);
    wr(`PPS_REG_CCM_LIM, 32'h0000_0005);
    wr(`PPS_REG_AR_BRK, 32'h0000_0014);
    wr(`PPS_REG_MAXPER, 32'h0000_0064);
    wr(`PPS_REG_TONMIN, 32'h0000_000A);
    rd(`PPS_REG_OV2_FLT, 32'h0000_000A, "filter readback");
    $display("t_regs done");
  endtask
  task t_start;
    wr(`PPS_REG_CTRL, 32'h0000_0001);
    wr(`PPS_REG_BUS_AVG, 32'h0000_0080);
    wr(`PPS_REG_AC_RMS, 32'h0000_0500);
    repeat (50) @(negedge clk);
    chk(bridge_en, 1'b0, "bridge under open loop");
    chk(boost_en, 1'b0, "boost under open loop");
    wr(`PPS_REG_BUS_AVG, 32'h0000_0600);
    wr(`PPS_REG_AC_RMS, 32'h0000_0500);
    wait_out(1, 1'b1);
    chk(bridge_en, 1'b1, "bridge after brown-in");
    wait_out(2, 1'b1);
    chk(gate, 1'b1, "gate switching");
    $display("t_start done");
  endtask
  task t_ocp;
    int n;
    @(posedge clk);
    ocp_after <= 8'h05;
    wait_out(2, 1'b0);
    wait_out(2, 1'b1);
    n = 0;
    while (gate === 1'b1 && n < 60) begin
      n++;
      @(negedge clk);
    end
    chk(n < 20, 1'b1, "on-time cut");
    wait_out(2, 1'b1);
    chk(gate, 1'b1, "next cycle started");
    @(posedge clk);
    ocp_after <= 8'h00;
    $display("t_ocp done");
  endtask
  task t_ovp;
    wr(`PPS_REG_BUS_AVG, 32'h0000_0900);
    wait_out(0, 1'b0);
    chk(bridge_en, 1'b1, "bridge kept in average overvoltage");
    rd(`PPS_REG_STATUS, 32'h0000_0114, "average overvoltage flag");
    wr(`PPS_REG_BUS_AVG, 32'h0000_0600);
    wait_out(0, 1'b1);
    chk(boost_en, 1'b1, "boost resumed");
    wr(`PPS_REG_BUS_AVG, 32'h0000_0700);
    @(posedge clk);
    comparator_overvoltage_stage <= 1'b1;
    repeat (5) @(negedge clk);
    chk(boost_en, 1'b1, "boost kept inside filter");
    wait_out(0, 1'b0);
    chk(bridge_en, 1'b1, "bridge kept in comparator overvoltage");
    @(posedge clk);
    comparator_overvoltage_stage <= 1'b0;
    wr(`PPS_REG_BUS_AVG, 32'h0000_0600);
    wait_out(0, 1'b1);
    chk(boost_en, 1'b1, "boost resumed");
    $display("t_ovp done");
  endtask
  task t_restart;
    wr(`PPS_REG_AC_RMS, 32'h0000_0100);
    wait_out(0, 1'b0);
    chk(bridge_en, 1'b1, "bridge kept in brownout");
    wr(`PPS_REG_BUS_AVG, 32'h0000_0080);
    wait_out(1, 1'b0);
    rd(`PPS_REG_STATUS, 32'h0000_0186, "restart state");
    repeat (40) @(negedge clk);
    rd(`PPS_REG_STATUS, 32'h0000_0102, "new startup after break");
    $display("t_restart done");
  endtask
  task t_ccm;
    wr(`PPS_REG_BUS_AVG, 32'h0000_0600);
    wr(`PPS_REG_AC_RMS, 32'h0000_0500);
    wait_out(2, 1'b1);
    @(posedge clk);
    ccm <= 1'b1;
    repeat (250) @(negedge clk);
    apb(1'b0, `PPS_REG_CCM_CNT, 32'h0000_0000);
    chk(q[15:0] != 16'h0000, 1'b1, "counter rising");
    @(posedge clk);
    ccm <= 1'b0;
    repeat (300) @(negedge clk);
    rd(`PPS_REG_CCM_CNT, 32'h0000_0000, "counter back to zero");
    @(posedge clk);
    ccm <= 1'b1;
    wait_out(1, 1'b0);
    chk(boost_en, 1'b0, "halted on long conduction");
    @(posedge clk);
    ccm <= 1'b0;
    $display("t_ccm done");
  endtask
  task t_uvp;
    wait_out(0, 1'b1);
    wr(`PPS_REG_UVP_BLK, 32'h0000_000A);
    wr(`PPS_REG_UVP_LVL, 32'h0000_0700);
    wait_out(0, 1'b0);
    chk(bridge_en, 1'b1, "bridge kept in undervoltage");
    rd(`PPS_REG_STATUS, 32'h0000_0144, "undervoltage flag");
    $display("t_uvp done");
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    uvlo_ok <= 1'b1;
    t_regs;
    t_start;
    t_ocp;
    t_ovp;
    t_restart;
    t_ccm;
    t_uvp;
    wrap_up;
  end
  initial begin
    #(8 * 40000);
    n_fail++;
    wrap_up;
  end
endmodule
